/* hw/bms_defs.svh */
`ifndef BMS_DEFS_SVH
`define BMS_DEFS_SVH

// Register byte offsets
`define BMS_OFF_CTRL      12'h000
`define BMS_OFF_CONFIG    12'h004
`define BMS_OFF_STATUS    12'h008
`define BMS_OFF_GAIN      12'h00c
`define BMS_OFF_RESULT    12'h010
`define BMS_OFF_TEMP      12'h014
`define BMS_OFF_OFFSET    12'h018
`define BMS_OFF_AZ        12'h01c
`define BMS_OFF_COEF_SPAN 12'h020
`define BMS_OFF_COEF_T1   12'h024
`define BMS_OFF_COEF_T2   12'h028
`define BMS_OFF_CONV      12'h02c

// Control register fields
`define BMS_CTRL_START    0
`define BMS_CTRL_CMDMODE  1
`define BMS_CTRL_FULL     2

// Configuration word fields
`define BMS_CFG_G1_LO     0
`define BMS_CFG_G1_HI     1
`define BMS_CFG_G2_LO     2
`define BMS_CFG_G2_HI     4
`define BMS_CFG_POL       5
`define BMS_CFG_RES_LO    6
`define BMS_CFG_RES_HI    8
`define BMS_CFG_OFS_LO    9
`define BMS_CFG_OFS_HI    11
`define BMS_CFG_RESET     12'h000

// Resolution limits in bits
`define BMS_RES_MIN       10
`define BMS_RES_MAX       16

// Wake-up time in microseconds
`define BMS_WAKE_US       2000
`define BMS_CLK_MHZ       50

`endif

/* hw/bms_pkg.sv */
package bms_pkg;

    typedef enum logic [3:0] {
        BMS_SLEEP   = 4'b0000,
        BMS_WAKE    = 4'b0001,
        BMS_LATCH   = 4'b0010,
        BMS_AZ_BR   = 4'b0011,
        BMS_MEAS_BR = 4'b0100,
        BMS_AZ_TP   = 4'b0101,
        BMS_MEAS_TP = 4'b0110,
        BMS_MEAS_OS = 4'b0111,
        BMS_CALC    = 4'b1000,
        BMS_DONE    = 4'b1001
    } bms_state_t;

    typedef enum logic [1:0] {
        BMS_MUX_SHORT  = 2'b00,
        BMS_MUX_BRIDGE = 2'b01,
        BMS_MUX_TEMP   = 2'b10
    } bms_mux_t;

endpackage

/* hw/bms_gain_decode.sv */
`timescale 1ns/10ps
// Gain and polarity decode from latched configuration bits
module bms_gain_decode
    import bms_pkg::*;
(
    input  wire logic [1:0] first_stage_gain_sel,
    input  wire logic [2:0] second_stage_gain_sel,
    input  wire logic       polarity_inv,
    output logic      [5:0] first_gain,
    output logic      [4:0] second_gain_x10,
    output logic            chopper_invert
);

    // First stage gain table
    always_comb begin
        case (first_stage_gain_sel)
            2'h0:    first_gain = 6'h0c;
            2'h1:    first_gain = 6'h14;
            2'h2:    first_gain = 6'h1e;
            2'h3:    first_gain = 6'h28;
            default: first_gain = 6'h0c;
        endcase
    end

    // Second stage gain in tenths: 11 + code
    assign second_gain_x10 = 5'h0b + {2'h0, second_stage_gain_sel};

    // Swapped sensor wiring is fixed by flipping the chopper phase
    assign chopper_invert = polarity_inv;

endmodule

/* hw/bms_calc_core.sv */
`timescale 1ns/10ps
// 18-bit correction core: offset removal, span and temperature terms
module bms_calc_core
    import bms_pkg::*;
#(
    parameter int W = 18
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         start,
    input  wire logic [W-1:0] raw_bridge,
    input  wire logic [W-1:0] raw_az,
    input  wire logic [W-1:0] raw_offset,
    input  wire logic [W-1:0] raw_temp,
    input  wire logic [W-1:0] coef_span,
    input  wire logic [W-1:0] coef_t1,
    input  wire logic [W-1:0] coef_t2,
    output logic      [W-1:0] result,
    output logic              done
);

    logic [W-1:0]   result_q, result_d;
    logic           done_q, done_d;
    logic [W-1:0]   corr;
    logic [2*W-1:0] span_prod;
    logic [2*W-1:0] t1_prod;
    logic [2*W-1:0] t2_prod;
    logic [2*W-1:0] tsq;

    // Offset removal, then span and coefficient terms in Q1.(W-1); temperature square from its top W bits
    always_comb begin
        corr      = raw_bridge - raw_az - raw_offset;
        span_prod = corr * coef_span;
        tsq       = raw_temp * raw_temp;
        t1_prod   = corr * coef_t1;
        t2_prod   = corr * coef_t2;
        result_d  = result_q;
        done_d    = 1'b0;
        if (start) begin
            // Products kept modulo core width, like the hardware datapath
            result_d = span_prod[2*W-2 -: W]
                     + t1_prod[2*W-2 -: W]
                     + t2_prod[2*W-2 -: W] + tsq[2*W-1 -: W];
            done_d   = 1'b1;
        end
    end

    // Result register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= '0;
            done_q   <= 1'b0;
        end else begin
            result_q <= result_d;
            done_q   <= done_d;
        end
    end

    assign result = result_q;
    assign done   = done_q;

endmodule

/* hw/bms_sequencer.sv */
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "bms_defs.svh"
// What this block does
// - In normal mode the block wakes from sleep, measures once and returns to sleep unaided.
// - Two modes exist, normal measurement mode and command mode for control and configuration.
// - Bridge, temperature and offset measurements select bridge pins, temperature sensor or shorted input.
// - A full measurement request runs every measurement kind over all inputs with no further request.
// - An amplifier auto-zero step precedes every bridge and every temperature measurement.
// - The lowest five configuration bits hold first-stage then second-stage gain selection.
// - First-stage codes 00, 01, 10, 11 select gains 12, 20, 30, 40.
// - Second-stage codes 000 to 111 select gains 1.1 to 1.8 in steps of 0.1.
// - A polarity bit of one inverts the chopper clock, zero leaves polarity alone.
// - Converter resolution is programmable from 10 to 16 bits.
// - An 18-bit core applies auto-zero, span and two stored-coefficient terms to the bridge value, then adds the unweighted temperature square.
// - System and sensor offset are removed using offset and auto-zero results.
// - A supply supervisor reset initialises all digital logic.
module bms_sequencer
    import bms_pkg::*;
#(
    parameter int W         = 18,
    parameter int WAKE_CYC  = `BMS_WAKE_US * `BMS_CLK_MHZ,
    parameter int CONV_BASE = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_done,
    input  wire logic [17:0] conv_data,
    output logic             conv_start,
    output logic      [4:0]  conv_resolution,
    output logic      [1:0]  mux_sel,
    output logic             az_active,
    output logic      [1:0]  first_stage_gain_sel,
    output logic      [2:0]  second_stage_gain_sel,
    output logic             chopper_invert,
    output logic      [5:0]  first_gain,
    output logic      [4:0]  second_gain_x10,
    output logic      [2:0]  converter_offset_shift,
    output logic             active_state
);

    // Register state
    logic [11:0]  cfg_q, cfg_d;
    logic         cmd_mode_q, cmd_mode_d;
    logic         full_q, full_d;
    logic [W-1:0] span_q, span_d, t1_q, t1_d, t2_q, t2_d;
    logic [31:0]  prdata_q, prdata_d;
    logic         wr_en, rd_en, addr_ok;
    logic         start_req;

    // Sequencer state
    bms_state_t   st_q, st_d;
    logic [31:0]  wait_q, wait_d;
    logic [5:0]   lat_q, lat_d;
    logic [2:0]   ofs_q, ofs_d;
    logic [4:0]   res_q, res_d;
    logic [W-1:0] br_q, br_d, tp_q, tp_d, os_q, os_d, az_q, az_d;
    logic         issued_q, issued_d;
    logic         busy_q, busy_d;
    logic         calc_start, calc_done;
    logic [W-1:0] calc_res;
    logic [W-1:0] out_q, out_d;
    logic         ovf_q, ovf_d;
    logic [2:0]   res_code;
    bms_mux_t     mux;

    // APB decode; zero wait states
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `BMS_OFF_CONV);
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = prdata_q;
    assign start_req = wr_en && (paddr == `BMS_OFF_CTRL) && pwdata[`BMS_CTRL_START];

    // Software registers
    always_comb begin
        cfg_d      = cfg_q;
        cmd_mode_d = cmd_mode_q;
        full_d     = full_q;
        span_d     = span_q;
        t1_d       = t1_q;
        t2_d       = t2_q;
        if (wr_en) begin
            case (paddr)
                `BMS_OFF_CTRL: begin
                    cmd_mode_d = pwdata[`BMS_CTRL_CMDMODE];
                    full_d     = pwdata[`BMS_CTRL_FULL];
                end
                `BMS_OFF_CONFIG:    cfg_d  = pwdata[11:0];
                `BMS_OFF_COEF_SPAN: span_d = pwdata[W-1:0];
                `BMS_OFF_COEF_T1:   t1_d   = pwdata[W-1:0];
                `BMS_OFF_COEF_T2:   t2_d   = pwdata[W-1:0];
                default: ;
            endcase
        end
    end

    // Read mux, registered in the setup phase so data is steady in access
    always_comb begin
        prdata_d = prdata_q;
        if (rd_en) begin
            case (paddr)
                `BMS_OFF_CTRL:      prdata_d = {29'h0, full_q, cmd_mode_q, busy_q};
                `BMS_OFF_CONFIG:    prdata_d = {20'h0, cfg_q};
                `BMS_OFF_STATUS:    prdata_d = {22'h0, ovf_q, busy_q, 4'h0, st_q};
                `BMS_OFF_GAIN:      prdata_d = {26'h0, lat_q};
                `BMS_OFF_RESULT:    prdata_d = {14'h0, out_q};
                `BMS_OFF_TEMP:      prdata_d = {14'h0, tp_q};
                `BMS_OFF_OFFSET:    prdata_d = {14'h0, os_q};
                `BMS_OFF_AZ:        prdata_d = {14'h0, az_q};
                `BMS_OFF_COEF_SPAN: prdata_d = {14'h0, span_q};
                `BMS_OFF_COEF_T1:   prdata_d = {14'h0, t1_q};
                `BMS_OFF_COEF_T2:   prdata_d = {14'h0, t2_q};
                `BMS_OFF_CONV:      prdata_d = {24'h0, ofs_q, res_q};
                default:            prdata_d = 32'h0;
            endcase
        end
    end

    // Resolution code above 6 clamps to 16 bits
    assign res_code = cfg_q[`BMS_CFG_RES_HI:`BMS_CFG_RES_LO];

    // Measurement sequence
    always_comb begin
        st_d       = st_q;
        wait_d     = wait_q;
        lat_d      = lat_q;
        ofs_d      = ofs_q;
        res_d      = res_q;
        br_d       = br_q;
        tp_d       = tp_q;
        os_d       = os_q;
        az_d       = az_q;
        issued_d   = issued_q;
        busy_d     = busy_q;
        out_d      = out_q;
        ovf_d      = ovf_q;
        calc_start = 1'b0;
        mux        = BMS_MUX_SHORT;
        if (calc_done) begin
            out_d = calc_res;
        end
        case (st_q)
            BMS_SLEEP: begin
                if (start_req) begin
                    busy_d = 1'b1;
                    wait_d = '0;
                    st_d   = cmd_mode_q ? BMS_LATCH : BMS_WAKE;
                end
            end
            BMS_WAKE: begin
                wait_d = wait_q + 32'h1;
                if (wait_q >= 32'(WAKE_CYC - 1)) begin
                    st_d = BMS_LATCH;
                end
            end
            BMS_LATCH: begin
                lat_d    = {cfg_q[`BMS_CFG_POL], cfg_q[`BMS_CFG_G2_HI:`BMS_CFG_G1_LO]};
                ofs_d    = cfg_q[`BMS_CFG_OFS_HI:`BMS_CFG_OFS_LO];
                res_d    = (res_code > 3'h6) ? 5'(`BMS_RES_MAX)
                         : 5'(`BMS_RES_MIN) + {2'h0, res_code};
                issued_d = 1'b0;
                st_d     = BMS_AZ_BR;
            end
            BMS_AZ_BR, BMS_AZ_TP, BMS_MEAS_BR, BMS_MEAS_TP, BMS_MEAS_OS: begin
                // Each step: one conversion on the selected input
                issued_d = 1'b1;
                if (conv_done && issued_q) begin
                    issued_d = 1'b0;
                    case (st_q)
                        BMS_AZ_BR:   begin az_d = conv_data; st_d = BMS_MEAS_BR; end
                        BMS_MEAS_BR: begin
                            br_d = conv_data;
                            st_d = full_q ? BMS_AZ_TP : BMS_MEAS_OS;
                        end
                        BMS_AZ_TP:   st_d = BMS_MEAS_TP;
                        BMS_MEAS_TP: begin tp_d = conv_data; st_d = BMS_MEAS_OS; end
                        default:     begin os_d = conv_data; st_d = BMS_CALC; end
                    endcase
                end
            end
            BMS_CALC: begin
                calc_start = 1'b1;
                ovf_d      = (br_q < az_q);
                st_d       = BMS_DONE;
            end
            BMS_DONE: begin
                if (calc_done) begin
                    busy_d = 1'b0;
                    st_d   = BMS_SLEEP;
                end
            end
            default: st_d = BMS_SLEEP;
        endcase
        // Input select per measurement kind
        case (st_q)
            BMS_AZ_BR, BMS_AZ_TP: mux = BMS_MUX_SHORT;
            BMS_MEAS_BR:          mux = BMS_MUX_BRIDGE;
            BMS_MEAS_TP:          mux = BMS_MUX_TEMP;
            BMS_MEAS_OS:          mux = BMS_MUX_SHORT;
            default:              mux = BMS_MUX_SHORT;
        endcase
    end

    // Supervisor reset drives presetn and clears all state except res_q, which loads 10 bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q      <= `BMS_CFG_RESET;
            cmd_mode_q <= 1'b0;
            full_q     <= 1'b0;
            span_q     <= '0;
            t1_q       <= '0;
            t2_q       <= '0;
            prdata_q   <= '0;
            st_q       <= BMS_SLEEP;
            wait_q     <= '0;
            lat_q      <= '0;
            ofs_q      <= '0;
            res_q      <= 5'(`BMS_RES_MIN);
            br_q       <= '0;
            tp_q       <= '0;
            os_q       <= '0;
            az_q       <= '0;
            issued_q   <= 1'b0;
            busy_q     <= 1'b0;
            out_q      <= '0;
            ovf_q      <= 1'b0;
        end else begin
            cfg_q      <= cfg_d;
            cmd_mode_q <= cmd_mode_d;
            full_q     <= full_d;
            span_q     <= span_d;
            t1_q       <= t1_d;
            t2_q       <= t2_d;
            prdata_q   <= prdata_d;
            st_q       <= st_d;
            wait_q     <= wait_d;
            lat_q      <= lat_d;
            ofs_q      <= ofs_d;
            res_q      <= res_d;
            br_q       <= br_d;
            tp_q       <= tp_d;
            os_q       <= os_d;
            az_q       <= az_d;
            issued_q   <= issued_d;
            busy_q     <= busy_d;
            out_q      <= out_d;
            ovf_q      <= ovf_d;
        end
    end

    // Conversion request: first cycle of a conversion step
    assign conv_start = !issued_q && ((st_q == BMS_AZ_BR) || (st_q == BMS_AZ_TP) || (st_q == BMS_MEAS_BR)
                        || (st_q == BMS_MEAS_TP) || (st_q == BMS_MEAS_OS));
    assign az_active  = (st_q == BMS_AZ_BR) || (st_q == BMS_AZ_TP);
    assign mux_sel    = mux;
    assign conv_resolution       = res_q;
    assign converter_offset_shift = ofs_q;
    assign first_stage_gain_sel  = lat_q[1:0];
    assign second_stage_gain_sel = lat_q[4:2];
    assign active_state          = (st_q != BMS_SLEEP);

    // Gain and polarity decode from latched copy only
    bms_gain_decode u_gain (
        .first_stage_gain_sel  (lat_q[1:0]),
        .second_stage_gain_sel (lat_q[4:2]),
        .polarity_inv          (lat_q[5]),
        .first_gain            (first_gain),
        .second_gain_x10       (second_gain_x10),
        .chopper_invert        (chopper_invert)
    );

    // Correction core
    bms_calc_core #(.W(W)) u_calc (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (calc_start),
        .raw_bridge (br_q),
        .raw_az     (az_q),
        .raw_offset (os_q),
        .raw_temp   (tp_q),
        .coef_span  (span_q),
        .coef_t1    (t1_q),
        .coef_t2    (t2_q),
        .result     (calc_res),
        .done       (calc_done)
    );

endmodule

/* testbench/bms_conv_model.sv */
`timescale 1ns/10ps
// Converter and bridge stand-in: answers each conversion after a short or long delay
module bms_conv_model
    import bms_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        conv_start,
    input  wire logic [1:0]  mux_sel,
    input  wire logic        az_active,
    input  wire logic        slow,
    output logic             conv_done,
    output logic      [17:0] conv_data
);
    logic [3:0] cnt_q;

    // Data toggles between answers so a stale sample never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 4'h0;
            conv_done <= 1'b0;
            conv_data <= 18'h0;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (conv_start) begin
                cnt_q <= slow ? 4'h7 : 4'h1;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    conv_done <= 1'b1;
                    // Source level follows the selected input
                    conv_data <= az_active ? 18'h00040 :
                                 (mux_sel == BMS_MUX_BRIDGE) ? 18'h21000 :
                                 (mux_sel == BMS_MUX_TEMP) ? 18'h18000 :
                                 18'h00080;
                end
            end
        end
    end
endmodule

/* testbench/bms_sequencer_sva.sv */
`timescale 1ns/10ps
// Port-level checker for the measurement sequencer
module bms_sequencer_sva
    import bms_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pready,
    input  wire logic       pslverr,
    input  wire logic       conv_start,
    input  wire logic [1:0] mux_sel,
    input  wire logic       az_active,
    input  wire logic [1:0] first_stage_gain_sel,
    input  wire logic [2:0] second_stage_gain_sel,
    input  wire logic       chopper_invert,
    input  wire logic [5:0] first_gain,
    input  wire logic [4:0] second_gain_x10,
    input  wire logic [4:0] conv_resolution,
    input  wire logic       active_state
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic seen_q, seen_d, az_q, az_d;

    // Seen a conversion this run; last conversion was an auto-zero
    always_comb begin
        seen_d = active_state ? (seen_q | conv_start) : 1'b0;
        az_d   = conv_start ? az_active : az_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
            az_q   <= 1'b0;
        end else begin
            seen_q <= seen_d;
            az_q   <= az_d;
        end
    end

    property p_gain1;
        first_gain == ((first_stage_gain_sel == 2'h0) ? 6'h0c : (first_stage_gain_sel == 2'h1) ? 6'h14 :
                       (first_stage_gain_sel == 2'h2) ? 6'h1e : 6'h28);
    endproperty
    a_gain1: assert property (p_gain1) else $error("first stage gain wrong");
    property p_gain2;
        second_gain_x10 == 5'h0b + {2'h0, second_stage_gain_sel};
    endproperty
    a_gain2: assert property (p_gain2) else $error("second stage gain wrong");
    property p_res;
        conv_resolution >= 5'h0a && conv_resolution <= 5'h10;
    endproperty
    a_res: assert property (p_res) else $error("resolution out of range");
    property p_hold;
        seen_q |-> $stable({first_stage_gain_sel, second_stage_gain_sel, chopper_invert});
    endproperty
    a_hold: assert property (p_hold) else $error("gain changed in sequence");
    property p_az_first;
        conv_start && !az_active && mux_sel != BMS_MUX_SHORT |-> az_q;
    endproperty
    a_az_first: assert property (p_az_first) else $error("measurement without auto-zero");
    property p_idle;
        !active_state |-> !conv_start && !az_active;
    endproperty
    a_idle: assert property (p_idle) else $error("conversion while asleep");
    property p_sleep;
        $rose(active_state) |-> ##[1:1000] !active_state;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no return to sleep");
    property p_pulse;
        conv_start |=> !conv_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("conversion start longer than one cycle");
    property p_err;
        pslverr |-> psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("error outside access phase");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");

    c_temp: cover property (conv_start && mux_sel == BMS_MUX_TEMP);
    c_err: cover property (pslverr);
    c_end: cover property ($fell(active_state));
endmodule

bind bms_sequencer bms_sequencer_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .mux_sel(mux_sel), .az_active(az_active),
    .first_stage_gain_sel(first_stage_gain_sel), .second_stage_gain_sel(second_stage_gain_sel),
    .chopper_invert(chopper_invert), .first_gain(first_gain), .second_gain_x10(second_gain_x10),
    .conv_resolution(conv_resolution), .active_state(active_state));

/* testbench/bms_sequencer_tb.sv */
`timescale 1ns/10ps
module bms_sequencer_tb
    import bms_pkg::*;
;
    localparam int WAKE = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
    logic        conv_done, conv_start, az_active, chopper_invert, active_state;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rng, rd;
    logic [17:0] conv_data;
    logic [4:0]  conv_resolution, second_gain_x10;
    logic [1:0]  mux_sel, first_stage_gain_sel;
    logic [2:0]  second_stage_gain_sel, converter_offset_shift;
    logic [5:0]  first_gain;
    logic [2:0]  log_q[$];
    int          bad_count, total_checks, cyc, t_first;

    bms_sequencer #(.WAKE_CYC(WAKE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
        .conv_resolution(conv_resolution), .mux_sel(mux_sel), .az_active(az_active),
        .first_stage_gain_sel(first_stage_gain_sel), .second_stage_gain_sel(second_stage_gain_sel),
        .chopper_invert(chopper_invert), .first_gain(first_gain), .second_gain_x10(second_gain_x10),
        .converter_offset_shift(converter_offset_shift), .active_state(active_state));

    bms_conv_model conv (.pclk(pclk), .presetn(presetn), .conv_start(conv_start), .mux_sel(mux_sel),
        .az_active(az_active), .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Log each conversion as auto-zero flag plus input, input masked during auto-zero
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1) begin
            if (log_q.size() == 0) t_first = cyc;
            log_q.push_back({az_active, az_active ? 2'b00 : mux_sel});
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Calibration choice: largest first-stage gain not above the optimum
    function automatic logic [1:0] g1_pick(input int opt);
        return (opt >= 40) ? 2'h3 : (opt >= 30) ? 2'h2 : (opt >= 20) ? 2'h1 : 2'h0;
    endfunction

    // Expected corrected result with unit span and no temperature coefficients
    function automatic logic [31:0] exp_res(input logic [17:0] br, az, os, tp);
        logic [35:0] sq;
        sq = tp * tp;
        return {14'h0, br - az - os + sq[35:18]};
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Start one run, disturb config mid-run, then check order and latched gains
    task automatic run_seq(input logic cmd, input logic full, input logic [31:0] cfg);
        logic [14:0] got;
        int          t0, i;
        apb(1'b1, 12'h004, cfg);
        // Mode bits go first: the start write acts on the mode already held
        apb(1'b1, 12'h000, {29'h0, full, cmd, 1'b0});
        log_q.delete();
        t0 = cyc;
        apb(1'b1, 12'h000, {29'h0, full, cmd, 1'b1});
        apb(1'b0, 12'h000, 32'h0);
        check({31'h0, rd[0]}, 32'h1);
        apb(1'b1, 12'h004, ~cfg);
        for (i = 0; i < 2000 && active_state !== 1'b0; i++) @(posedge pclk);
        if (i == 2000) begin
            bad_count++;
            results();
        end
        got = 15'h0;
        foreach (log_q[k]) got = (got << 3) | {12'h0, log_q[k]};
        check(log_q.size(), full ? 5 : 3);
        check({17'h0, got}, full ? 32'h4310 : 32'h108);
        check({31'h0, (t_first - t0 >= WAKE + 2)}, {31'h0, !cmd});
        check({30'h0, first_stage_gain_sel}, {30'h0, cfg[1:0]});
        check({29'h0, second_stage_gain_sel}, {29'h0, cfg[4:2]});
        check({26'h0, first_gain}, cfg[1] ? (cfg[0] ? 32'h28 : 32'h1e) : (cfg[0] ? 32'h14 : 32'h0c));
        check({27'h0, second_gain_x10}, 32'h0b + {29'h0, cfg[4:2]});
        check({31'h0, chopper_invert}, {31'h0, cfg[5]});
        check({27'h0, conv_resolution}, (cfg[8:6] > 3'h6) ? 32'h10 : 32'h0a + {29'h0, cfg[8:6]});
        check({29'h0, converter_offset_shift}, {29'h0, cfg[11:9]});
        apb(1'b0, 12'h00c, 32'h0);
        check({26'h0, rd[5:0]}, {26'h0, cfg[5:0]});
        // Unit span: corrected value is bridge less both offsets plus the square term
        apb(1'b0, 12'h010, 32'h0);
        check(rd, exp_res(18'h21000, 18'h00040, 18'h00080, 18'h18000));
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        rng = 32'd92;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({26'h0, first_gain}, 32'h0c);
        check({27'h0, second_gain_x10}, 32'h0b);
        check({27'h0, conv_resolution}, 32'h0a);
        check({28'h0, mux_sel, active_state, conv_start}, 32'h0);
        $display("test reset finished");
        apb(1'b0, 12'h030, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b0, 12'h002, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test unmapped finished");
        // Span coefficient of one in the core's fixed-point format
        apb(1'b1, 12'h020, 32'h00020000);
        run_seq(1'b0, 1'b1, 32'h00000fff);
        run_seq(1'b1, 1'b0, 32'h00000000);
        $display("test corners finished");
        for (int i = 0; i < 64; i++) begin
            rng = xs(rng);
            slow <= rng[3];
            run_seq(rng[0], rng[1], {20'h0, rng[6:4], i[2:0], i[5:2], g1_pick(12 + int'(rng[13:9]))});
        end
        $display("test random sequences finished");
        results();
    end
endmodule
